// File: inc/tw_pkg.sv
package tw_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam int unsigned AW          = 8;
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_FORCE  = 8'h04;
	localparam logic [7:0]  ADDR_COUNT  = 8'h08;
	localparam logic [7:0]  ADDR_CMPA   = 8'h0C;
	localparam logic [7:0]  ADDR_CMPB   = 8'h10;
	localparam logic [7:0]  ADDR_CAPT   = 8'h14;
	localparam logic [7:0]  ADDR_FLAGS  = 8'h18;

	// ------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------
	localparam int unsigned CTRL_WGM_LSB = 0;
	localparam int unsigned CTRL_COMA_LSB = 4;
	localparam int unsigned CTRL_COMB_LSB = 6;
	localparam int unsigned CTRL_CS_LSB  = 8;
	localparam int unsigned CTRL_W       = 11;
	localparam logic [10:0] CTRL_RST     = 11'h000;
	localparam int unsigned FRC_A        = 0;
	localparam int unsigned FRC_B        = 1;
	localparam int unsigned FLG_OVF      = 0;
	localparam int unsigned FLG_CMPA     = 1;
	localparam int unsigned FLG_CMPB     = 2;
	localparam int unsigned FLG_CAPT     = 3;
	localparam logic [15:0] VAL_RST      = 16'h0000;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// ------------------------------------------------------------
	// Counter limits and prescaler terminal counts
	// ------------------------------------------------------------
	localparam logic [15:0] TOP_MAX  = 16'hFFFF;
	localparam logic [15:0] TOP_8B   = 16'h00FF;
	localparam logic [15:0] TOP_9B   = 16'h01FF;
	localparam logic [15:0] TOP_10B  = 16'h03FF;
	localparam logic [9:0]  PS_DIV1  = 10'h000;
	localparam logic [9:0]  PS_DIV8  = 10'h007;
	localparam logic [9:0]  PS_DIV64 = 10'h03F;
	localparam logic [9:0]  PS_DIV256 = 10'h0FF;
	localparam logic [9:0]  PS_DIV1024 = 10'h3FF;

	typedef enum logic [3:0] {
		WGM_NORMAL   = 4'h0,
		WGM_CTC_A    = 4'h4,
		WGM_FPWM8    = 4'h5,
		WGM_FPWM9    = 4'h6,
		WGM_FPWM10   = 4'h7,
		WGM_CTC_CAP  = 4'hC,
		WGM_FPWM_CAP = 4'hE,
		WGM_FPWM_A   = 4'hF
	} tw_wgm_e;

	typedef enum logic [1:0] {
		COM_OFF    = 2'h0,
		COM_TOGGLE = 2'h1,
		COM_CLEAR  = 2'h2,
		COM_SET    = 2'h3
	} tw_com_e;

endpackage : tw_pkg

// File: verilog/tw_timer16.sv
// Summary of operation
// RQ1 - Reset clears internal waveform output state
// RQ2 - Nonzero output mode overrides port value
// RQ3 - Software enables pin direction before use
// RQ4 - Output mode never affects input capture
// RQ5 - Output mode zero leaves state unchanged
// RQ6 - New mode acts next match; force acts now
// RQ7 - Counting depends on waveform mode only
// RQ8 - Normal mode increments, wraps FFFF to zero
// RQ9 - Normal overflow flag sets when count zero
// RQ10 - Interrupt acknowledge clears overflow flag
// RQ11 - Counter writable anytime in normal mode
// RQ12 - Clear-on-match resets on compare A/capture
// RQ13 - Unbuffered TOP below count runs to wrap
// RQ14 - Reaching TOP sets compare A/capture flag
// RQ15 - Mode one toggles channel A each match
// RQ16 - Prescaler divides by 1,8,64,256,1024
// RQ17 - Clear-on-match overflow only at FFFF rollover
// RQ18 - Fast PWM counts bottom to TOP, restarts
// RQ19 - Fast PWM set/clear on match and TOP
// RQ20 - Fast PWM TOP fixed or register, then clear
// RQ21 - Software keeps register TOP at least 3
// RQ22 - Fast PWM match sets channel compare flag
// RQ23 - Fast PWM compare A buffered, loaded at TOP
// RQ24 - Fast PWM TOP sets overflow, TOP-defining flag
// RQ25 - Force acts like match without flags
// RQ26 - Fast PWM modes two/three: normal/inverted; code makes mode two inverted, mode three normal
// RQ27 - Non-PWM modes two clear, three set
// RQ28 - Four-bit waveform mode; other codes reserved
`timescale 1ns/1ps
`default_nettype none

module tw_timer16 import tw_pkg::*; (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// AXI4-Lite write address
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Interrupt controller
	input  wire logic        ovf_int_ack,
	output logic [3:0]       flags_o,
	// Capture input pin
	input  wire logic        capture_pin,
	// General port logic
	input  wire logic        port_a_value,
	input  wire logic        channel_a_pin_direction,
	input  wire logic        port_b_value,
	input  wire logic        channel_b_pin_direction,
	// Waveform pins
	output logic             pin_a_o,
	output logic             pin_a_oe,
	output logic             pin_b_o,
	output logic             pin_b_oe
);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] data,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Next waveform output state of one channel
	function automatic logic out_next(
		input logic       st,
		input logic [1:0] com,
		input logic       pwm,
		input logic       hit,
		input logic       top_hit,
		input logic       tog_ok
	);
		logic r;
		r = st;
		if (!pwm) begin
			if (hit) begin
				case (com)
					COM_TOGGLE: r = ~st;               // RQ15
					COM_CLEAR:  r = 1'b0;              // RQ27
					COM_SET:    r = 1'b1;              // RQ27
					default:    r = st;                // RQ5
				endcase
			end
		end else if (hit) begin
			case (com)
				COM_CLEAR: r = 1'b1;                   // RQ19 RQ26
				COM_SET:   r = 1'b0;                   // RQ19 RQ26
				COM_TOGGLE: r = tog_ok ? ~st : st;
				default:   r = st;                     // RQ5
			endcase
		end else if (top_hit) begin
			case (com)
				COM_CLEAR: r = 1'b0;                   // RQ19
				COM_SET:   r = 1'b1;                   // RQ19
				default:   r = st;
			endcase
		end
		return r;
	endfunction : out_next

	// ------------------------------------------------------------
	// Reset synchroniser
	// ------------------------------------------------------------
	logic rst_s1_q;
	logic rst_ok_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_q <= 1'b0;
			rst_ok_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_ok_q <= rst_s1_q;
		end
	end

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [CTRL_W-1:0] ctrl_q;
	logic [15:0]       cnt_q;
	logic [15:0]       cnt_d;
	logic [15:0]       cmpa_buf_q;
	logic [15:0]       cmpa_act_q;
	logic [15:0]       cmpa_act_d;
	logic [15:0]       cmpb_q;
	logic [15:0]       capt_q;
	logic [15:0]       capt_d;
	logic [3:0]        flag_q;
	logic [3:0]        flag_d;
	logic              block_q;
	logic              out_a_q;
	logic              out_b_q;
	logic [9:0]        ps_q;
	logic [2:0]        cap_sync_q;

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic [AW-1:0] awaddr_q;
	logic [AW-1:0] araddr_q;
	logic [31:0]   wdata_q;
	logic [3:0]    wstrb_q;
	logic          aw_full_q;
	logic          w_full_q;
	logic          ar_full_q;

	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs  = s_axi_wvalid & s_axi_wready;
	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire wr_en = aw_full_q & w_full_q & ~s_axi_bvalid;
	wire rd_en = ar_full_q & ~s_axi_rvalid;

	wire wr_ctrl  = wr_en & (awaddr_q == ADDR_CTRL);
	wire wr_force = wr_en & (awaddr_q == ADDR_FORCE);
	wire wr_count = wr_en & (awaddr_q == ADDR_COUNT);
	wire wr_cmpa  = wr_en & (awaddr_q == ADDR_CMPA);
	wire wr_cmpb  = wr_en & (awaddr_q == ADDR_CMPB);
	wire wr_capt  = wr_en & (awaddr_q == ADDR_CAPT);
	wire wr_flags = wr_en & (awaddr_q == ADDR_FLAGS);
	wire wr_hit   = wr_ctrl | wr_force | wr_count | wr_cmpa
	              | wr_cmpb | wr_capt | wr_flags;

	wire [31:0] wr_count_v = merge({16'h0000, cnt_q}, wdata_q, wstrb_q);
	wire [31:0] wr_ctrl_v  = merge({21'h00000, ctrl_q}, wdata_q, wstrb_q);
	wire [31:0] wr_cmpa_v  = merge({16'h0000, cmpa_buf_q}, wdata_q,
	                               wstrb_q);
	wire [31:0] wr_cmpb_v  = merge({16'h0000, cmpb_q}, wdata_q, wstrb_q);
	wire [31:0] wr_capt_v  = merge({16'h0000, capt_q}, wdata_q, wstrb_q);
	wire [3:0]  frc_bits   = wstrb_q[0] ? wdata_q[3:0] : 4'h0;
	wire [3:0]  clr_bits   = (wr_flags & wstrb_q[0]) ? wdata_q[3:0]
	                                                 : 4'h0;

	logic [31:0] rd_val;
	logic        rd_ok;

	always_comb begin
		rd_val = 32'h00000000;
		rd_ok  = 1'b1;
		case (araddr_q)
			ADDR_CTRL:  rd_val = {21'h00000, ctrl_q};
			ADDR_FORCE: rd_val = 32'h00000000;
			ADDR_COUNT: rd_val = {16'h0000, cnt_q};
			ADDR_CMPA:  rd_val = {16'h0000, cmpa_buf_q};
			ADDR_CMPB:  rd_val = {16'h0000, cmpb_q};
			ADDR_CAPT:  rd_val = {16'h0000, capt_q};
			ADDR_FLAGS: rd_val = {28'h0000000, flag_q};
			default:    rd_ok  = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_ok_q) begin
		if (!rst_ok_q) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_arready <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= RESP_OKAY;
			s_axi_rdata   <= 32'h00000000;
			aw_full_q     <= 1'b0;
			w_full_q      <= 1'b0;
			ar_full_q     <= 1'b0;
			awaddr_q      <= 8'h00;
			araddr_q      <= 8'h00;
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
		end else begin
			if (aw_hs) begin
				awaddr_q      <= s_axi_awaddr;
				aw_full_q     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (w_hs) begin
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				w_full_q     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_en) begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (ar_hs) begin
				araddr_q      <= s_axi_araddr;
				ar_full_q     <= 1'b1;
				s_axi_arready <= 1'b0;
			end
			if (rd_en) begin
				ar_full_q    <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	wire [3:0] wgm   = ctrl_q[CTRL_WGM_LSB +: 4];             // RQ28
	wire [1:0] com_a = ctrl_q[CTRL_COMA_LSB +: 2];
	wire [1:0] com_b = ctrl_q[CTRL_COMB_LSB +: 2];
	wire [2:0] cs    = ctrl_q[CTRL_CS_LSB +: 3];

	wire is_ctc  = (wgm == WGM_CTC_A) | (wgm == WGM_CTC_CAP);
	wire is_pwm  = (wgm == WGM_FPWM8) | (wgm == WGM_FPWM9)
	             | (wgm == WGM_FPWM10) | (wgm == WGM_FPWM_CAP)
	             | (wgm == WGM_FPWM_A);                      // RQ18
	wire top_cap = (wgm == WGM_CTC_CAP) | (wgm == WGM_FPWM_CAP);
	wire top_a   = (wgm == WGM_CTC_A) | (wgm == WGM_FPWM_A);

	logic [15:0] top_v;

	always_comb begin
		case (wgm)
			WGM_FPWM8:   top_v = TOP_8B;                      // RQ20
			WGM_FPWM9:   top_v = TOP_9B;                      // RQ20
			WGM_FPWM10:  top_v = TOP_10B;                     // RQ20
			WGM_CTC_A,
			WGM_FPWM_A:  top_v = cmpa_act_q;                  // RQ12 RQ20
			WGM_CTC_CAP,
			WGM_FPWM_CAP: top_v = capt_q;                     // RQ12 RQ20
			default:     top_v = TOP_MAX;                     // RQ8
		endcase
	end

	// ------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------
	logic [9:0] ps_lim;

	always_comb begin
		case (cs)
			3'h1:    ps_lim = PS_DIV1;                        // RQ16
			3'h2:    ps_lim = PS_DIV8;                        // RQ16
			3'h3:    ps_lim = PS_DIV64;                       // RQ16
			3'h4:    ps_lim = PS_DIV256;                      // RQ16
			default: ps_lim = PS_DIV1024;                     // RQ16
		endcase
	end

	wire run  = (cs != 3'h0) & (cs < 3'h6);
	wire tick = run & (ps_q == ps_lim);

	always_ff @(posedge clk or negedge rst_ok_q) begin
		if (!rst_ok_q) begin
			ps_q <= 10'h000;
		end else begin
			ps_q <= (tick | ~run) ? 10'h000 : ps_q + 10'h001;
		end
	end

	// ------------------------------------------------------------
	// Counter, matches and flags
	// ------------------------------------------------------------
	wire at_top  = (cnt_q == top_v);
	wire at_max  = (cnt_q == TOP_MAX);
	wire restart = tick & (is_ctc | is_pwm) & at_top;     // RQ12 RQ13
	wire match_a = tick & ~block_q & (cnt_q == cmpa_act_q);
	wire match_b = tick & ~block_q & (cnt_q == cmpb_q);
	wire top_hit = tick & at_top & ~block_q;
	wire ovf_set = is_pwm ? restart                         // RQ24
	                      : tick & at_max;                  // RQ9 RQ17
	wire cap_set = top_cap ? top_hit & (is_ctc | is_pwm)    // RQ14 RQ24
	                       : cap_sync_q[1] & ~cap_sync_q[2];
	wire frc_a   = wr_force & frc_bits[FRC_A] & ~is_pwm;    // RQ6
	wire frc_b   = wr_force & frc_bits[FRC_B] & ~is_pwm;    // RQ6
	wire tog_a   = (wgm == WGM_FPWM_A);

	always_comb begin
		cnt_d = restart ? VAL_RST : cnt_q + 16'h0001;       // RQ8 RQ18
		if (!tick) begin
			cnt_d = cnt_q;
		end
		if (wr_count) begin
			cnt_d = wr_count_v[15:0];                       // RQ11
		end
	end

	always_comb begin
		cmpa_act_d = cmpa_act_q;
		if (!is_pwm) begin
			cmpa_act_d = cmpa_buf_q;                        // RQ13
		end else if (restart) begin
			cmpa_act_d = cmpa_buf_q;                        // RQ23
		end
	end

	always_comb begin
		capt_d = capt_q;
		if (!top_cap && cap_set) begin
			capt_d = cnt_q;                                 // RQ4
		end
		if (wr_capt) begin
			capt_d = wr_capt_v[15:0];
		end
	end

	always_comb begin
		flag_d = flag_q & ~clr_bits;
		if (ovf_int_ack) begin
			flag_d[FLG_OVF] = 1'b0;                         // RQ10
		end
		flag_d[FLG_OVF]  = flag_d[FLG_OVF] | ovf_set;       // RQ9
		flag_d[FLG_CMPA] = flag_d[FLG_CMPA] | match_a       // RQ22
		                 | (top_a & top_hit);               // RQ14
		flag_d[FLG_CMPB] = flag_d[FLG_CMPB] | match_b;      // RQ22
		flag_d[FLG_CAPT] = flag_d[FLG_CAPT] | cap_set;
	end

	always_ff @(posedge clk or negedge rst_ok_q) begin
		if (!rst_ok_q) begin
			ctrl_q     <= CTRL_RST;
			cnt_q      <= VAL_RST;
			cmpa_buf_q <= VAL_RST;
			cmpa_act_q <= VAL_RST;
			cmpb_q     <= VAL_RST;
			capt_q     <= VAL_RST;
			flag_q     <= 4'h0;
			block_q    <= 1'b0;
			cap_sync_q <= 3'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= wr_ctrl_v[CTRL_W-1:0];            // RQ6 RQ7
			end
			if (wr_cmpa) begin
				cmpa_buf_q <= wr_cmpa_v[15:0];
			end
			if (wr_cmpb) begin
				cmpb_q <= wr_cmpb_v[15:0];
			end
			cnt_q      <= cnt_d;
			cmpa_act_q <= cmpa_act_d;
			capt_q     <= capt_d;
			flag_q     <= flag_d;
			block_q    <= wr_count | (block_q & ~tick);
			cap_sync_q <= {cap_sync_q[1:0], capture_pin};
		end
	end

	// ------------------------------------------------------------
	// Waveform output state and pin override
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_ok_q) begin
		if (!rst_ok_q) begin
			out_a_q  <= 1'b0;                               // RQ1
			out_b_q  <= 1'b0;                               // RQ1
			pin_a_o  <= 1'b0;
			pin_a_oe <= 1'b0;
			pin_b_o  <= 1'b0;
			pin_b_oe <= 1'b0;
			flags_o  <= 4'h0;
		end else begin
			out_a_q  <= out_next(out_a_q, com_a, is_pwm,
			                     match_a | frc_a, top_hit,
			                     tog_a);                     // RQ25
			out_b_q  <= out_next(out_b_q, com_b, is_pwm,
			                     match_b | frc_b, top_hit,
			                     1'b0);                      // RQ25
			pin_a_o  <= (com_a != COM_OFF) ? out_a_q
			                               : port_a_value;   // RQ2
			pin_b_o  <= (com_b != COM_OFF) ? out_b_q
			                               : port_b_value;   // RQ2
			pin_a_oe <= channel_a_pin_direction;            // RQ2 RQ3
			pin_b_oe <= channel_b_pin_direction;            // RQ2 RQ3
			flags_o  <= flag_q;
		end
	end

endmodule : tw_timer16

`default_nettype wire

// File: verification/tw_timer16_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module tw_timer16_asserts import tw_pkg::*; (
	// Clock and reset
	input wire logic          clk,
	input wire logic          rstn,
	// Register bus
	input wire logic          s_axi_awvalid,
	input wire logic          s_axi_awready,
	input wire logic          s_axi_wvalid,
	input wire logic          s_axi_wready,
	input wire logic [1:0]    s_axi_bresp,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic          s_axi_arvalid,
	input wire logic          s_axi_arready,
	input wire logic [31:0]   s_axi_rdata,
	input wire logic [1:0]    s_axi_rresp,
	input wire logic          s_axi_rvalid,
	input wire logic          s_axi_rready,
	// Port logic
	input wire logic          channel_a_pin_direction,
	input wire logic          pin_a_oe
);
	logic [2:0] up_q;

	// Settles once the internal reset synchroniser has let go
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			up_q <= 3'h0;
		else if (up_q != 3'h7)
			up_q <= up_q + 3'h1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	chk_oe_follows_dir: assert property (
		up_q == 3'h7 |-> pin_a_oe == $past(channel_a_pin_direction))
		else $error("pin enable does not follow direction bit");
	chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	chk_rd_answer: assert property (
		s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
		else $error("read response late");
	chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped");
	chk_aw_refused: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	chk_unmapped_err: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr > ADDR_FLAGS
		|-> ##2 s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
endmodule : tw_timer16_asserts

bind tw_timer16 tw_timer16_asserts tw_timer16_asserts_i (
	.clk(clk), .rstn(rstn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.channel_a_pin_direction(channel_a_pin_direction),
	.pin_a_oe(pin_a_oe));

`default_nettype wire

// File: verification/tw_port_model.sv
`timescale 1ns/1ps
`default_nettype none

module tw_port_model (
	// Software settings
	input wire logic [1:0] dir_set,
	input wire logic [1:0] val_set,
	// Port register outputs
	output logic     [1:0] port_dir,
	output logic     [1:0] port_val,
	// Pads
	input wire logic [1:0] drv_o,
	input wire logic [1:0] drv_oe,
	output logic     [1:0] pad
);
	assign port_dir = dir_set;
	assign port_val = val_set;
	// Undriven pad floats to its pull-up
	assign pad[0] = drv_oe[0] ? drv_o[0] : 1'b1;
	assign pad[1] = drv_oe[1] ? drv_o[1] : 1'b1;
endmodule : tw_port_model

`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
	$display("ERROR %0t: got %0h expected %0h", $time, a, e); end end

module testbench import tw_pkg::*;;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, ack = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, dir = 2'b00, val = 2'b00, pdir, pval, po, poe;
	logic [1:0] pad, eb;
	logic [33:0] er;
	logic cap = 1'b0;
	logic [31:0] rdata;
	logic [3:0] flags;
	logic st;
	int bad_count = 0, check_count = 0, cyc = 0, seed = 32'hab73, w, n;
	logic [1:0] exp_b[$];
	logic [33:0] exp_r[$];
	int coms[5] = '{3, 2, 1, 0, 1};
	int wgms[5] = '{5, 6, 7, 14, 15};
	int tops[5] = '{'hFF, 'h1FF, 'h3FF, 'h20, 'h30};

	always #2 clk = ~clk;

	tw_timer16 tw_timer16_i (.clk(clk), .rstn(rstn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .ovf_int_ack(ack),
		.flags_o(flags), .capture_pin(cap), .port_a_value(pval[0]),
		.channel_a_pin_direction(pdir[0]), .port_b_value(pval[1]),
		.channel_b_pin_direction(pdir[1]), .pin_a_o(po[0]),
		.pin_a_oe(poe[0]), .pin_b_o(po[1]), .pin_b_oe(poe[1]));

	tw_port_model tw_port_model_i (.dir_set(dir), .val_set(val),
		.port_dir(pdir), .port_val(pval), .drv_o(po), .drv_oe(poe),
		.pad(pad));

	// Result watcher: oldest note against each bus answer
	always @(posedge clk) begin
		cyc++;
		if (rvalid && rready) begin
			er = exp_r.pop_front();
			`CHK({rresp, rdata}, er)
		end
		if (bvalid && bready) begin
			eb = exp_b.pop_front();
			`CHK(bresp, eb)
		end
		if (cyc == 60000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = RESP_OKAY);
		int k;
		exp_b.push_back(r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid && bready) && k < 100);
		if (!(bvalid && bready)) bad_count++;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		int k;
		exp_r.push_back(e);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid && rready) && k < 100);
		if (!(rvalid && rready)) bad_count++;
		rready <= 1'b0;
	endtask : rd

	task automatic set_mode(input logic [31:0] c);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_COUNT, 32'h0);
		wr(ADDR_FLAGS, 32'hF);
		wr(ADDR_CTRL, c);
	endtask : set_mode

	// Width of the next full pulse at level lv on pad ch
	task automatic wid(input int ch, input logic lv);
		n = 0;
		while (pad[ch] === lv && n < 3000) begin @(posedge clk); n++; end
		while (pad[ch] !== lv && n < 3000) begin @(posedge clk); n++; end
		w = 0;
		while (pad[ch] === lv && w < 3000) begin @(posedge clk); w++; end
	endtask : wid

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		rd(ADDR_CTRL, {RESP_OKAY, 32'h0});
		rd(ADDR_FLAGS, {RESP_OKAY, 32'h0});
		rd(ADDR_FORCE, {RESP_OKAY, 32'h0});
		rd(8'h1C, {RESP_SLVERR, 32'h0});
		wr(8'h20, 32'h1, RESP_SLVERR);
		wr(ADDR_COUNT, 32'h1234);
		rd(ADDR_COUNT, {RESP_OKAY, 32'h1234});
		$display("register test done");
		dir <= 2'b11;
		val <= 2'($random(seed));
		st = 1'b0;
		foreach (coms[i]) begin
			wr(ADDR_CTRL, 32'(coms[i]) << CTRL_COMA_LSB);
			wr(ADDR_FORCE, 32'h1);
			case (coms[i])
				1: st = ~st;
				2: st = 1'b0;
				3: st = 1'b1;
				default: ;
			endcase
			repeat (2) @(posedge clk);
			`CHK(pad[0], coms[i] != 0 ? st : pval[0])
		end
		wr(ADDR_CTRL, 32'h0);
		repeat (4) begin
			val <= 2'($random(seed));
			repeat (3) @(posedge clk);
			`CHK(pad[0], pval[0])
		end
		dir <= 2'b00;
		repeat (3) @(posedge clk);
		`CHK(pad, 2'b11)
		dir <= 2'b11;
		rd(ADDR_FLAGS, {RESP_OKAY, 32'h0});
		$display("force test done");
		wr(ADDR_CMPA, 32'h8000);
		wr(ADDR_CMPB, 32'h8000);
		wr(ADDR_FLAGS, 32'hF);
		wr(ADDR_COUNT, 32'hFFF0);
		wr(ADDR_CTRL, 32'h100);
		n = 0;
		while (flags[FLG_OVF] !== 1'b1 && n < 200) begin @(posedge clk); n++; end
		`CHK(flags[FLG_OVF], 1'b1)
		wr(ADDR_CTRL, 32'h0);
		rd(ADDR_FLAGS, {RESP_OKAY, 32'h1});
		@(posedge clk);
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		rd(ADDR_FLAGS, {RESP_OKAY, 32'h0});
		wr(ADDR_COUNT, 32'h55);
		wr(ADDR_CTRL, 32'hF0);
		cap <= 1'b1;
		repeat (5) @(posedge clk);
		cap <= 1'b0;
		rd(ADDR_CAPT, {RESP_OKAY, 32'h55});
		rd(ADDR_FLAGS, {RESP_OKAY, 32'h8});
		$display("normal test done");
		wr(ADDR_CMPA, 32'h3);
		wr(ADDR_CMPB, 32'h100);
		for (int k = 0; k < 2; k++) begin
			set_mode(32'((k + 1) << CTRL_CS_LSB) | 32'h14);
			wid(0, 1'b1);
			wid(0, 1'b1);
			`CHK(w, (k ? 8 : 1) * (1 + 3))
			rd(ADDR_FLAGS, {RESP_OKAY, 32'h2});
		end
		$display("clear on match test done");
		wr(ADDR_CAPT, 32'h20);
		wr(ADDR_CMPA, 32'h30);
		wr(ADDR_CMPB, 32'h10);
		foreach (wgms[i]) begin
			set_mode(32'h180 | 32'(wgms[i]));
			wid(1, 1'b1);
			wid(1, 1'b1);
			`CHK(w, tops[i] - 'h10)
		end
		rd(ADDR_FLAGS, {RESP_OKAY, 32'h7});
		set_mode(32'h1CF);
		wid(1, 1'b0);
		wid(1, 1'b0);
		`CHK(w, 'h30 - 'h10)
		wr(ADDR_CMPA, 32'h40);
		wid(1, 1'b0);
		wid(1, 1'b0);
		`CHK(w, 'h40 - 'h10)
		$display("fast pwm test done");
		tally_and_finish();
	end
endmodule : testbench

`default_nettype wire
